/* src/pie_consts.vh */
/*
  Constants for the programming interface entry block: timing counts,
  enable-string echo bytes, link codes and reserved data RAM windows.
  Assumes a 50 MHz system clock; figures are converted in the code.
*/
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH
`define PIE_CLK_HZ 50000000
`define PIE_HOLD_US 5100
`define PIE_HOLD_CYC ((`PIE_HOLD_US * (`PIE_CLK_HZ / 1000000)))
`define PIE_SYNC_B2 8'h53
`define PIE_SYNC_B3 8'hAA
`define PIE_LINK_NONE 2'h0
`define PIE_LINK_SPI 2'h1
`define PIE_LINK_UART 2'h2
`define PIE_LINK_USB 2'h3
`define PIE_USB_WIN0_LO 16'h0E00
`define PIE_USB_WIN0_HI 16'h0FFF
`define PIE_USB_WIN1_LO 16'h0500
`define PIE_USB_WIN1_HI 16'h0507
`define PIE_UART_SEL_P20 1'h1
`endif

/* src/pie_sync.v */
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input may change at any time relative to sys_clk.
*/
`timescale 1ns/10ps
module pie_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire sys_clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta;

  // Only the second flop is ever read by other logic.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* src/pie_entry.v */
/*
  Programming interface entry: measures the external reset hold, keeps the
  self-entry state, watches the programming SPI port, UART and USB for the
  enable string, picks the first link that completes it, drives the
  link outputs, and tells the rest of the chip which pins stay pulled-up
  inputs and which data RAM windows the USB logic owns.
  Assumes byte-level receivers outside deliver strobes on sys_clk, and
  that the reset pin arrives raw and is synchronised here.
*/
`timescale 1ns/10ps
`include "pie_consts.vh"
// How it works
// - Reset pin held 5.1 ms arms SPI and UART for an enable string.
// - Self-entry bit set or lock bit clear makes every reset except power-on boot armed.
// - Self-entry state equals long-hold state except USB is also allowed.
// - Self-entry bit clears only on power cycle or link clear command.
// - Cleared lock bit returns set only through full flash erase.
// - Only the programming SPI port answers; the other SPI port stays silent.
// - In programming mode all unused port pins are pulled-up inputs.
// - UART serves only when routed to P2.0 and P2.1.
// - USB link reserves data RAM 0E00h-0FFFh and 0500h-0507h.
// - Calibration image leaves results in data RAM for readout.
// - Link outputs stay undriven until two enable bytes arrive on that link.
// - Echo 53h on byte three and AAh on byte four to synchronise.
// - First link with a valid enable string is the only link until reset.
module pie_entry #(
  parameter HOLD_CYC = `PIE_HOLD_CYC,
  parameter EN_LEN = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ext_reset_pin_n,
  input wire por_pulse,
  input wire chip_reset_pulse,
  input wire self_entry_set,
  input wire self_entry_clear_cmd,
  input wire lock_clear_cmd,
  input wire chip_erase_done,
  input wire uart_on_p2,
  input wire spi_rx_valid,
  input wire [7:0] spi_rx_byte,
  input wire spi2_rx_valid,
  input wire uart_rx_valid,
  input wire [7:0] uart_rx_byte,
  input wire usb_rx_valid,
  input wire [7:0] usb_rx_byte,
  input wire [15:0] ram_addr,
  output reg [7:0] spi_tx_byte,
  output reg spi_miso_oe,
  output reg [7:0] uart_tx_byte,
  output reg uart_tx_oe,
  output reg [7:0] usb_tx_byte,
  output reg prog_mode,
  output reg [1:0] prog_link,
  output reg synced,
  output reg self_entry_enable_bit,
  output reg self_entry_lock_bit,
  output reg self_entry_programming_state,
  output reg gpio_pullup_inputs,
  output wire ram_usb_reserved,
  output wire spi2_respond
);
  localparam N_LINK = 3;
  wire pin_n_s;
  wire link_clear;
  wire link_free;
  wire spi_drive;
  wire uart_drive;
  wire [2:0] rx_vld;
  wire [2:0] link_ok;
  wire [2:0] done;
  wire [8:0] cnt_w;
  wire [23:0] rx_bytes;
  reg [31:0] hold_cnt;
  reg hold_reached;
  reg pin_n_d;
  reg armed;
  reg usb_allowed;

  pie_sync #(.RESET_VAL(1'b1)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(ext_reset_pin_n),
    .q(pin_n_s)
  );

  // A byte of all ones is what an idle pulled-up link reads, so it restarts the string.
  function byte_ok;
    input [7:0] b;
    begin
      byte_ok = (b != 8'hFF);
    end
  endfunction

  // Link code for a link index; the index order is SPI, UART, USB.
  function [1:0] link_code;
    input integer idx;
    begin
      case (idx)
        0: link_code = `PIE_LINK_SPI;
        1: link_code = `PIE_LINK_UART;
        default: link_code = `PIE_LINK_USB;
      endcase
    end
  endfunction

  // Echo value for the byte being shifted at a given string position.
  function [7:0] echo_for;
    input [2:0] pos;
    begin
      case (pos)
        3'd2: echo_for = `PIE_SYNC_B2;
        3'd3: echo_for = `PIE_SYNC_B3;
        default: echo_for = 8'h00;
      endcase
    end
  endfunction

  // Hold counter on sys_clk; saturates so a very long hold is still one entry.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 32'h00000000;
      hold_reached <= 1'b0;
      pin_n_d <= 1'b1;
    end else begin
      pin_n_d <= pin_n_s;
      if (por_pulse) begin
        hold_cnt <= 32'h00000000;
        hold_reached <= 1'b0;
      end else if (!pin_n_s) begin
        if (hold_cnt < HOLD_CYC) begin
          hold_cnt <= hold_cnt + 32'h00000001;
        end else begin
          hold_reached <= 1'b1;
        end
      end else begin
        // Cleared on release, after the arming logic has seen the old value.
        hold_cnt <= 32'h00000000;
        hold_reached <= 1'b0;
      end
    end
  end

  // Self-entry bit and lock bit; sets beat clears when both come together.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      self_entry_enable_bit <= 1'b0;
      self_entry_lock_bit <= 1'b1;
    end else begin
      if (self_entry_set) begin
        self_entry_enable_bit <= 1'b1;
      end else if (por_pulse || self_entry_clear_cmd) begin
        self_entry_enable_bit <= 1'b0;
      end
      if (chip_erase_done) begin
        self_entry_lock_bit <= 1'b1;
      end else if (lock_clear_cmd) begin
        self_entry_lock_bit <= 1'b0;
      end
    end
  end

  // Arming: a long hold released, or any reset except power-on while self-entry is active.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      usb_allowed <= 1'b0;
      self_entry_programming_state <= 1'b0;
    end else begin
      self_entry_programming_state <= self_entry_enable_bit || !self_entry_lock_bit;
      if (por_pulse) begin
        armed <= 1'b0;
        usb_allowed <= 1'b0;
      end else if (pin_n_s && !pin_n_d && hold_reached) begin
        armed <= 1'b1;
        usb_allowed <= self_entry_programming_state;
      end else if ((chip_reset_pulse || (pin_n_s && !pin_n_d)) &&
                   self_entry_programming_state) begin
        armed <= 1'b1;
        usb_allowed <= 1'b1;
      end else if (chip_reset_pulse || (!pin_n_s && pin_n_d)) begin
        armed <= 1'b0;
        usb_allowed <= 1'b0;
      end
    end
  end

  // Shared qualifiers; any reset source drops the selected link at once.
  assign link_clear = por_pulse || chip_reset_pulse || !pin_n_s;
  assign link_free = (prog_link == `PIE_LINK_NONE);
  assign rx_vld = {usb_rx_valid, uart_rx_valid, spi_rx_valid};
  assign rx_bytes = {usb_rx_byte, uart_rx_byte, spi_rx_byte};
  // UART needs the P2 routing and USB needs the self-entry boot.
  assign link_ok = {usb_allowed, uart_on_p2, 1'b1};

  // One enable-string counter per link; a link loses its count once another wins.
  genvar gi;
  generate
    for (gi = 0; gi < N_LINK; gi = gi + 1) begin : gen_link
      reg [2:0] cnt;
      wire mine;
      wire take;
      wire good;
      assign mine = (prog_link == link_code(gi));
      assign good = byte_ok(rx_bytes[8 * gi + 7:8 * gi]);
      assign take = armed && link_ok[gi] && rx_vld[gi] &&
                    (link_free || mine) && (cnt < EN_LEN);
      assign done[gi] = take && good && (cnt == EN_LEN - 1);
      assign cnt_w[3 * gi + 2:3 * gi] = cnt;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= 3'h0;
        end else if (link_clear || !(link_free || mine)) begin
          cnt <= 3'h0;
        end else if (take && good) begin
          cnt <= cnt + 3'h1;
        end else if (take) begin
          cnt <= 3'h0;
        end
      end
    end
  endgenerate

  // Each output stage turns on after two string bytes; the first link there keeps it.
  assign spi_drive = (cnt_w[2:0] >= 3'h2) && !uart_tx_oe &&
                     (link_free || prog_link == `PIE_LINK_SPI);
  assign uart_drive = uart_on_p2 && (cnt_w[5:3] >= 3'h2) && !spi_miso_oe && !spi_drive &&
                      (link_free || prog_link == `PIE_LINK_UART);

  // Outside arming and programming the second SPI port works as usual; programming traffic never reaches it.
  assign spi2_respond = spi2_rx_valid && !armed && !prog_mode;

  // The USB logic owns two data RAM windows; other addresses keep calibration results.
  assign ram_usb_reserved = (prog_link == `PIE_LINK_USB) &&
    (((ram_addr >= `PIE_USB_WIN0_LO) && (ram_addr <= `PIE_USB_WIN0_HI)) ||
     ((ram_addr >= `PIE_USB_WIN1_LO) && (ram_addr <= `PIE_USB_WIN1_HI)));

  // Output enables and echo bytes; cleared with the link so the pins go quiet in reset.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso_oe <= 1'b0;
      uart_tx_oe <= 1'b0;
      spi_tx_byte <= 8'h00;
      uart_tx_byte <= 8'h00;
      usb_tx_byte <= 8'h00;
    end else if (link_clear) begin
      spi_miso_oe <= 1'b0;
      uart_tx_oe <= 1'b0;
      spi_tx_byte <= 8'h00;
      uart_tx_byte <= 8'h00;
      usb_tx_byte <= 8'h00;
    end else begin
      spi_miso_oe <= spi_drive;
      uart_tx_oe <= uart_drive;
      spi_tx_byte <= echo_for(cnt_w[2:0]);
      uart_tx_byte <= echo_for(cnt_w[5:3]);
      usb_tx_byte <= echo_for(cnt_w[8:6]);
    end
  end

  // The first completed string claims the link; SPI wins a tie, then UART.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_link <= `PIE_LINK_NONE;
      prog_mode <= 1'b0;
      synced <= 1'b0;
      gpio_pullup_inputs <= 1'b0;
    end else if (link_clear) begin
      prog_link <= `PIE_LINK_NONE;
      prog_mode <= 1'b0;
      synced <= 1'b0;
      gpio_pullup_inputs <= 1'b0;
    end else if (link_free && (done != 3'h0)) begin
      prog_link <= done[0] ? `PIE_LINK_SPI : (done[1] ? `PIE_LINK_UART : `PIE_LINK_USB);
      prog_mode <= 1'b1;
      synced <= 1'b1;
      gpio_pullup_inputs <= 1'b1;
    end
  end
endmodule

/* sim/pie_entry_asserts.sv */
/* Checker for pie_entry port relations.
   Assumes pie_consts.vh is on the include path. */
`timescale 1ns/10ps
`include "pie_consts.vh"
module pie_entry_chk (
  input wire sys_clk, input wire rst_n, input wire ext_reset_pin_n,
  input wire por_pulse, input wire chip_reset_pulse, input wire self_entry_clear_cmd,
  input wire chip_erase_done, input wire uart_on_p2, input wire [15:0] ram_addr,
  input wire spi_miso_oe, input wire uart_tx_oe, input wire prog_mode,
  input wire [1:0] prog_link, input wire self_entry_enable_bit,
  input wire self_entry_lock_bit, input wire gpio_pullup_inputs,
  input wire ram_usb_reserved, input wire spi2_respond
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_usb_window: assert property (
    ram_usb_reserved == (prog_link == `PIE_LINK_USB &&
    ((ram_addr >= 16'h0E00 && ram_addr <= 16'h0FFF) ||
    (ram_addr >= 16'h0500 && ram_addr <= 16'h0507)))) else $error("usb window wrong");
  a_spi2_silent: assert property (prog_mode |-> !spi2_respond) else $error("spi2 answered");
  a_pullup_mode: assert property (prog_mode |-> gpio_pullup_inputs) else $error("no pullups");
  a_uart_route: assert property (uart_tx_oe |-> uart_on_p2) else $error("uart not on p2");
  a_link_sticky: assert property (prog_link != `PIE_LINK_NONE && ext_reset_pin_n &&
    $past(ext_reset_pin_n) && $past(ext_reset_pin_n, 2) &&
    !chip_reset_pulse && !$past(chip_reset_pulse) && !por_pulse |=>
    prog_link == $past(prog_link)) else $error("link changed");
  a_oe_link: assert property (spi_miso_oe |-> !uart_tx_oe) else $error("two links drive");
  a_lock_erase: assert property ($rose(self_entry_lock_bit) |->
    chip_erase_done || $past(chip_erase_done)) else $error("lock set without erase");
  a_enable_clear: assert property ($fell(self_entry_enable_bit) |->
    $past(self_entry_clear_cmd) || $past(por_pulse)) else $error("enable bit lost");
  c_spi: cover property (prog_link == `PIE_LINK_SPI);
  c_uart: cover property (prog_link == `PIE_LINK_UART);
  c_usb: cover property (prog_link == `PIE_LINK_USB && ram_usb_reserved);
endmodule
bind pie_entry pie_entry_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .ext_reset_pin_n(ext_reset_pin_n), .por_pulse(por_pulse),
  .chip_reset_pulse(chip_reset_pulse), .self_entry_clear_cmd(self_entry_clear_cmd),
  .chip_erase_done(chip_erase_done), .uart_on_p2(uart_on_p2), .ram_addr(ram_addr),
  .spi_miso_oe(spi_miso_oe), .uart_tx_oe(uart_tx_oe), .prog_mode(prog_mode),
  .prog_link(prog_link), .self_entry_enable_bit(self_entry_enable_bit),
  .self_entry_lock_bit(self_entry_lock_bit), .gpio_pullup_inputs(gpio_pullup_inputs),
  .ram_usb_reserved(ram_usb_reserved), .spi2_respond(spi2_respond));

/* sim/pie_prog_model.sv */
/* Programming unit model: one-cycle byte strobes per link.
   Assumes strobes are taken on the rising sys_clk edge. */
`timescale 1ns/10ps
module pie_prog_model (
  input wire sys_clk,
  output reg [2:0] vld,
  output reg [7:0] dat
);
  initial vld = 3'h0;
  initial dat = 8'h00;
  // The calibration reference is not modelled: it is offered only on SPI or UART
  // setups and stays off while these strobes run.
  // Writing calibration results into the config area is left to the unit.
  // Data is inverted after each strobe so a stale byte never matches.
  task send(input [1:0] lk, input [7:0] b);
    begin
      @(negedge sys_clk);
      vld = 3'h1 << lk;
      dat = b;
      @(negedge sys_clk);
      vld = 3'h0;
      dat = ~b;
      repeat (6) @(negedge sys_clk);
    end
  endtask
endmodule

/* sim/testbench.sv */
/* Self-checking bench for pie_entry.
   Assumes the model and checker files are compiled before it. */
`timescale 1ns/10ps
`include "pie_consts.vh"
module testbench;
  localparam HOLD = 40;
  reg [16:0] rows [0:7];
  reg sys_clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, crst = 1'b0, se_set = 1'b0;
  reg se_clr = 1'b0, lk_clr = 1'b0, erase = 1'b0, p2 = 1'b1, s2v = 1'b0, por = 1'b0;
  reg [15:0] addr = 16'h0000;
  wire [2:0] vld;
  wire [7:0] dat, stx, utx, btx;
  wire oe_s, oe_u, pm, seb, slk, sps, pu, rsv, syn, s2r;
  wire [1:0] link;
  integer n_fail = 0, checked = 0, k;
  // The programmer keeps the system clock running for the whole run.
  always #10 sys_clk = ~sys_clk;
  pie_prog_model i_pie_prog_model (.sys_clk(sys_clk), .vld(vld), .dat(dat));
  pie_entry #(.HOLD_CYC(HOLD)) i_pie_entry (.sys_clk(sys_clk), .rst_n(rst_n),
    .ext_reset_pin_n(pin_n), .por_pulse(por), .chip_reset_pulse(crst),
    .self_entry_set(se_set), .self_entry_clear_cmd(se_clr), .lock_clear_cmd(lk_clr),
    .chip_erase_done(erase), .uart_on_p2(p2), .spi_rx_valid(vld[0]), .spi_rx_byte(dat),
    .spi2_rx_valid(s2v), .uart_rx_valid(vld[1]), .uart_rx_byte(dat),
    .usb_rx_valid(vld[2]), .usb_rx_byte(dat), .ram_addr(addr), .spi_tx_byte(stx),
    .spi_miso_oe(oe_s), .uart_tx_byte(utx), .uart_tx_oe(oe_u), .usb_tx_byte(btx),
    .prog_mode(pm), .prog_link(link), .synced(syn), .self_entry_enable_bit(seb),
    .self_entry_lock_bit(slk), .self_entry_programming_state(sps),
    .gpio_pullup_inputs(pu), .ram_usb_reserved(rsv), .spi2_respond(s2r));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task hold(input integer n);
    begin
      pin_n = 1'b0;
      repeat (n) @(negedge sys_clk);
      pin_n = 1'b1;
      repeat (6) @(negedge sys_clk);
    end
  endtask
  // Sends n bytes of an enable string; host byte values only need to differ from idle.
  task en(input [1:0] lk, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        i_pie_prog_model.send(lk, 8'h11 + j[7:0]);
      end
    end
  endtask
  // Watchdog sized well above the expected run of under five hundred cycles.
  initial begin
    #400000;
    n_fail = n_fail + 1;
    complete_run;
  end
  initial begin
    // Address rows: reserved flag above the address.
    rows[0] = 17'h00DFF;
    rows[1] = 17'h10E00;
    rows[2] = 17'h10FFF;
    rows[3] = 17'h01000;
    rows[4] = 17'h004FF;
    rows[5] = 17'h10500;
    rows[6] = 17'h10507;
    rows[7] = 17'h00508;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    chk({7'h00, oe_s}, 8'h00);
    hold(HOLD - 8);
    en(0, 4);
    chk({6'h00, link}, {6'h00, `PIE_LINK_NONE});
    hold(HOLD + 4);
    en(0, 1);
    chk({7'h00, oe_s}, 8'h00);
    en(0, 1);
    chk({6'h00, oe_s, oe_u}, 8'h02);
    chk(stx, `PIE_SYNC_B2);
    en(0, 1);
    chk(stx, `PIE_SYNC_B3);
    en(0, 1);
    s2v = 1'b1;
    en(1, 4);
    chk({6'h00, link}, {6'h00, `PIE_LINK_SPI});
    chk({6'h00, pm, pu}, 8'h03);
    chk({7'h00, syn}, 8'h01);
    chk({7'h00, s2r}, 8'h00);
    s2v = 1'b0;
    p2 = 1'b0;
    hold(HOLD + 4);
    en(1, 4);
    chk({5'h00, link, oe_u}, 8'h00);
    p2 = 1'b1;
    hold(HOLD + 4);
    en(2, 4);
    chk({6'h00, link}, {6'h00, `PIE_LINK_NONE});
    en(1, 2);
    chk({6'h00, oe_s, oe_u}, 8'h01);
    chk(utx, `PIE_SYNC_B2);
    en(1, 2);
    chk({6'h00, link}, {6'h00, `PIE_LINK_UART});
    se_set = 1'b1;
    hold(1);
    se_set = 1'b0;
    crst = 1'b1;
    hold(1);
    crst = 1'b0;
    chk({6'h00, seb, sps}, 8'h03);
    en(2, 2);
    chk(btx, `PIE_SYNC_B2);
    en(2, 2);
    chk({6'h00, link}, {6'h00, `PIE_LINK_USB});
    for (k = 0; k < 8; k = k + 1) begin
      addr = rows[k][15:0];
      @(negedge sys_clk);
      chk({7'h00, rsv}, {7'h00, rows[k][16]});
    end
    se_clr = 1'b1;
    hold(1);
    se_clr = 1'b0;
    chk({6'h00, seb, slk}, 8'h01);
    lk_clr = 1'b1;
    hold(1);
    lk_clr = 1'b0;
    chk({6'h00, sps, slk}, 8'h02);
    erase = 1'b1;
    hold(1);
    erase = 1'b0;
    chk({7'h00, slk}, 8'h01);
    // A power-on pulse is the other way to clear the self-entry bit.
    se_set = 1'b1;
    repeat (3) @(negedge sys_clk);
    se_set = 1'b0;
    chk({7'h00, seb}, 8'h01);
    por = 1'b1;
    @(negedge sys_clk);
    por = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, seb}, 8'h00);
    complete_run;
  end
endmodule
